// ---- hdl/tcc_axil.sv ----
/*
  axi4-lite slave front end: one write and one read under way at a time.
  assumes: register file answers rd_data and hit combinationally.
*/
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_axil #(
  parameter int AW = 12
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  tcc_rbus_if.bus            rb
);
  import tcc_pkg::*;

  tcc_wstate_t   wst_r, wst_nxt;
  logic          aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [AW-1:0] aw_addr_r, aw_addr_nxt;
  tcc_byte_t     w_data_r, w_data_nxt;
  logic          w_lane_r, w_lane_nxt;
  logic          awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0]    bresp_nxt, rresp_nxt;
  logic [31:0]   rdata_nxt;

  function automatic logic aligned(input logic [AW-1:0] a);
    aligned = (a[`TCC_IDX_LSB-1:0] == 2'h0) && (a[AW-1:`TCC_IDX_MSB+1] == '0);
  endfunction

  // ----------------------------------------------------------------------
  // register port strobes
  // ----------------------------------------------------------------------
  assign rb.wr_en   = (wst_r == TCC_W_IDLE) && aw_got_r && w_got_r;
  assign rb.wr_idx  = aw_addr_r[`TCC_IDX_MSB:`TCC_IDX_LSB];
  assign rb.wr_data = w_data_r;
  assign rb.wr_lane = w_lane_r && aligned(aw_addr_r);
  assign rb.rd_en   = s_axi_arvalid && s_axi_arready;
  assign rb.rd_idx  = s_axi_araddr[`TCC_IDX_MSB:`TCC_IDX_LSB];

  // ----------------------------------------------------------------------
  // channel next state
  // ----------------------------------------------------------------------
  always_comb begin
    wst_nxt     = wst_r;
    aw_got_nxt  = aw_got_r || (s_axi_awvalid && s_axi_awready);
    w_got_nxt   = w_got_r || (s_axi_wvalid && s_axi_wready);
    aw_addr_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr_r;
    w_data_nxt  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : w_data_r;
    w_lane_nxt  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : w_lane_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    case (wst_r)
      TCC_W_IDLE: begin
        if (rb.wr_en) begin
          wst_nxt    = TCC_W_RESP;
          aw_got_nxt = 1'b0;
          w_got_nxt  = 1'b0;
          bvalid_nxt = 1'b1;
          bresp_nxt  = (rb.wr_hit && aligned(aw_addr_r)) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
        end
      end
      TCC_W_RESP: begin
        if (s_axi_bready) begin
          wst_nxt    = TCC_W_IDLE;
          bvalid_nxt = 1'b0;
        end
      end
      default: begin
        wst_nxt = TCC_W_IDLE;
      end
    endcase
    awready_nxt = (wst_nxt == TCC_W_IDLE) && !aw_got_nxt;
    wready_nxt  = (wst_nxt == TCC_W_IDLE) && !w_got_nxt;
    rvalid_nxt  = s_axi_rvalid;
    rdata_nxt   = s_axi_rdata;
    rresp_nxt   = s_axi_rresp;
    if (rb.rd_en) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, rb.rd_data};
      rresp_nxt  = (rb.rd_hit && aligned(s_axi_araddr)) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wst_r         <= TCC_W_IDLE;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= `TCC_RST_BYTE;
      w_lane_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TCC_RESP_OKAY;
    end else begin
      wst_r         <= wst_nxt;
      aw_got_r      <= aw_got_nxt;
      w_got_r       <= w_got_nxt;
      aw_addr_r     <= aw_addr_nxt;
      w_data_r      <= w_data_nxt;
      w_lane_r      <= w_lane_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt;
      s_axi_rresp   <= rresp_nxt;
    end
  end
endmodule

// ---- hdl/tcc_cfg.svh ----
/*
  register indices, reset values, field positions and bus codes of the
  timer compare/capture register block.
  assumes: included by its bare name wherever a constant is needed.
*/
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TCC_IDX_CAP_LO   8'h22
`define TCC_IDX_CAP_HI   8'h23
`define TCC_IDX_CMPB_LO  8'h24
`define TCC_IDX_CMPB_HI  8'h25
`define TCC_IDX_CMPA_LO  8'h26
`define TCC_IDX_CMPA_HI  8'h27
`define TCC_IDX_STATUS   8'h30
`define TCC_IDX_MASK     8'h31
`define TCC_IDX_CTRL     8'h32

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define TCC_RST_BYTE     8'h00
`define TCC_RST_WORD     16'h0000
`define TCC_RST_EVT      3'h0
`define TCC_RST_CTRL     2'h0
`define TCC_EVT_CMPA     0
`define TCC_EVT_CMPB     1
`define TCC_EVT_CAP      2
`define TCC_CTRL_SRC     0
`define TCC_CTRL_EDGE    1
`define TCC_HI           15:8
`define TCC_LO           7:0

// ----------------------------------------------------------------------
// bus codes
// ----------------------------------------------------------------------
`define TCC_RESP_OKAY    2'h0
`define TCC_RESP_SLVERR  2'h2
`define TCC_IDX_MSB      9
`define TCC_IDX_LSB      2

`endif

// ---- hdl/tcc_cmp.sv ----
/*
  one compare channel: equality of compare value and counter per counter step.
  assumes: tick marks each new counter state.
*/
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_cmp (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              tick,
  input  wire tcc_pkg::tcc_word_t counter_value,
  input  wire tcc_pkg::tcc_word_t compare_value,
  output logic                   match_r
);
  import tcc_pkg::*;

  logic match_nxt;

  always_comb begin
    match_nxt = tick && (counter_value == compare_value);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      match_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
    end
  end
endmodule

// ---- hdl/tcc_pkg.sv ----
/*
  types shared by the timer compare/capture register block.
  assumes: compiled before every other file of the block.
*/
package tcc_pkg;

  typedef logic [15:0] tcc_word_t;
  typedef logic [7:0]  tcc_byte_t;
  typedef logic [2:0]  tcc_evt_t;

  typedef enum logic [1:0] {
    TCC_W_IDLE = 2'b00,
    TCC_W_RESP = 2'b01
  } tcc_wstate_t;

endpackage

// ---- hdl/tcc_rbus_if.sv ----
/*
  simple register access port between the bus slave and the register file.
  assumes: one clock; strobes last one cycle.
*/
`timescale 1ns/1ps
interface tcc_rbus_if;
  import tcc_pkg::*;

  logic      wr_en;
  tcc_byte_t wr_idx;
  tcc_byte_t wr_data;
  logic      wr_lane;
  logic      wr_hit;
  logic      rd_en;
  tcc_byte_t rd_idx;
  tcc_byte_t rd_data;
  logic      rd_hit;

  modport bus  (output wr_en, wr_idx, wr_data, wr_lane, rd_en, rd_idx,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_en, wr_idx, wr_data, wr_lane, rd_en, rd_idx,
                output wr_hit, rd_data, rd_hit);
endinterface

// ---- hdl/tcc_regs.sv ----
/*
  timer compare/capture holding registers with shared high-byte latch,
  two compare channels, input capture, sticky event flags and interrupt.
  assumes: counter, prescaler and waveform unit sit outside; the counter
  presents its value with a one-cycle tick per new state.
*/
// Contract
// [RL1] compare a value built from high and low bytes
// [RL2] compare b value built the same way
// [RL3] each compare value checked against counter continuously; the code compares only in cycles with counter_tick
// [RL4] match feeds interrupt flag and waveform pin event
// [RL5] compare writes pass through high-byte latch
// [RL6] one latch shared by all 16-bit registers
// [RL7] capture loads counter on pin or comparator event
// [RL8] capture high byte bits 15:8, low 7:0
// [RL9] high byte first; low read latches high byte
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_regs #(
  parameter int AW = 12
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [AW-1:0]      s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [AW-1:0]      s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire tcc_pkg::tcc_word_t counter_value,
  input  wire logic               counter_tick,
  input  wire logic               capture_input_pin,
  input  wire logic               comparator_out,
  output logic                    match_a,
  output logic                    match_b,
  output logic                    irq
);
  import tcc_pkg::*;

  tcc_rbus_if rb ();

  tcc_word_t cmp_a_r, cmp_a_nxt, cmp_b_r, cmp_b_nxt, cap_r, cap_nxt;
  tcc_byte_t temp_r, temp_nxt;
  tcc_evt_t  flag_r, flag_nxt, mask_r, mask_nxt, evt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic      src_prev_r, src_now, cap_evt, irq_nxt, wr_go;
  logic [1:0] hit_match;

  function automatic logic idx_known(input tcc_byte_t i);
    case (i)
      `TCC_IDX_CAP_LO, `TCC_IDX_CAP_HI, `TCC_IDX_CMPB_LO, `TCC_IDX_CMPB_HI,
      `TCC_IDX_CMPA_LO, `TCC_IDX_CMPA_HI, `TCC_IDX_STATUS, `TCC_IDX_MASK,
      `TCC_IDX_CTRL: idx_known = 1'b1;
      default: idx_known = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // bus slave and compare channels
  // ----------------------------------------------------------------------
  tcc_axil #(.AW(AW)) u_bus (
    .clk           (clk),
    .resetn        (resetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rb            (rb)
  );

  tcc_word_t cmp_val [2];
  assign cmp_val[0] = cmp_a_r;
  assign cmp_val[1] = cmp_b_r;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_cmp
      tcc_cmp u_cmp (
        .clk           (clk),
        .resetn        (resetn),
        .tick          (counter_tick),
        .counter_value (counter_value),
        .compare_value (cmp_val[g]), // RL3
        .match_r       (hit_match[g])
      );
    end
  endgenerate

  assign match_a = hit_match[0]; // RL4
  assign match_b = hit_match[1]; // RL4

  // ----------------------------------------------------------------------
  // capture source and edge
  // ----------------------------------------------------------------------
  assign src_now = ctrl_r[`TCC_CTRL_SRC] ? comparator_out : capture_input_pin;
  assign cap_evt = ctrl_r[`TCC_CTRL_EDGE] ? (src_now && !src_prev_r) : (!src_now && src_prev_r);
  assign evt     = {cap_evt, hit_match[1], hit_match[0]}; // RL4
  assign wr_go   = rb.wr_en && rb.wr_lane;

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  assign rb.wr_hit = idx_known(rb.wr_idx);
  assign rb.rd_hit = idx_known(rb.rd_idx);

  always_comb begin
    case (rb.rd_idx)
      `TCC_IDX_CAP_LO:  rb.rd_data = cap_r[`TCC_LO]; // RL8
      `TCC_IDX_CAP_HI:  rb.rd_data = temp_r; // RL9
      `TCC_IDX_CMPB_LO: rb.rd_data = cmp_b_r[`TCC_LO];
      `TCC_IDX_CMPB_HI: rb.rd_data = cmp_b_r[`TCC_HI];
      `TCC_IDX_CMPA_LO: rb.rd_data = cmp_a_r[`TCC_LO];
      `TCC_IDX_CMPA_HI: rb.rd_data = cmp_a_r[`TCC_HI];
      `TCC_IDX_STATUS:  rb.rd_data = {5'h00, flag_r};
      `TCC_IDX_MASK:    rb.rd_data = {5'h00, mask_r};
      `TCC_IDX_CTRL:    rb.rd_data = {6'h00, ctrl_r};
      default:          rb.rd_data = `TCC_RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------------
  always_comb begin
    cmp_a_nxt = cmp_a_r;
    cmp_b_nxt = cmp_b_r;
    cap_nxt   = cap_r;
    temp_nxt  = temp_r;
    mask_nxt  = mask_r;
    ctrl_nxt  = ctrl_r;
    flag_nxt  = flag_r;
    if (rb.rd_en && rb.rd_idx == `TCC_IDX_CAP_LO) begin
      temp_nxt = cap_r[`TCC_HI]; // RL9
    end
    if (wr_go) begin
      case (rb.wr_idx)
        `TCC_IDX_CAP_HI, `TCC_IDX_CMPB_HI, `TCC_IDX_CMPA_HI: temp_nxt = rb.wr_data; // RL5 RL6
        `TCC_IDX_CAP_LO:  cap_nxt   = {temp_r, rb.wr_data}; // RL8
        `TCC_IDX_CMPB_LO: cmp_b_nxt = {temp_r, rb.wr_data}; // RL2
        `TCC_IDX_CMPA_LO: cmp_a_nxt = {temp_r, rb.wr_data}; // RL1
        `TCC_IDX_STATUS:  flag_nxt  = flag_r & ~rb.wr_data[2:0];
        `TCC_IDX_MASK:    mask_nxt  = rb.wr_data[2:0];
        `TCC_IDX_CTRL:    ctrl_nxt  = rb.wr_data[1:0];
        default:          temp_nxt  = temp_nxt;
      endcase
    end
    if (cap_evt) begin
      cap_nxt = counter_value; // RL7
    end
    flag_nxt = flag_nxt | evt; // RL4
    irq_nxt  = |(flag_nxt & mask_nxt);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmp_a_r    <= `TCC_RST_WORD;
      cmp_b_r    <= `TCC_RST_WORD;
      cap_r      <= `TCC_RST_WORD;
      temp_r     <= `TCC_RST_BYTE;
      mask_r     <= `TCC_RST_EVT;
      flag_r     <= `TCC_RST_EVT;
      ctrl_r     <= `TCC_RST_CTRL;
      src_prev_r <= 1'b0;
      irq        <= 1'b0;
    end else begin
      cmp_a_r    <= cmp_a_nxt;
      cmp_b_r    <= cmp_b_nxt;
      cap_r      <= cap_nxt;
      temp_r     <= temp_nxt;
      mask_r     <= mask_nxt;
      flag_r     <= flag_nxt;
      ctrl_r     <= ctrl_nxt;
      src_prev_r <= src_now;
      irq        <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_rl1_cmpa;
    wr_go && rb.wr_idx == `TCC_IDX_CMPA_LO |=> cmp_a_r == {$past(temp_r), $past(rb.wr_data)};
  endproperty
  a_rl1_cmpa: assert property (p_rl1_cmpa) else $error("compare a not built from latch and low byte"); // RL1

  property p_rl2_cmpb;
    wr_go && rb.wr_idx == `TCC_IDX_CMPB_LO |=> cmp_b_r[`TCC_HI] == $past(temp_r);
  endproperty
  a_rl2_cmpb: assert property (p_rl2_cmpb) else $error("compare b high byte not from latch"); // RL2

  property p_rl3_match;
    counter_tick && counter_value == cmp_a_r |=> match_a;
  endproperty
  a_rl3_match: assert property (p_rl3_match) else $error("compare a match missed"); // RL3

  property p_rl4_flag;
    match_b |=> flag_r[`TCC_EVT_CMPB] && (irq || !mask_r[`TCC_EVT_CMPB]);
  endproperty
  a_rl4_flag: assert property (p_rl4_flag) else $error("match did not reach flag or interrupt"); // RL4

  property p_rl5_hold;
    wr_go && rb.wr_idx == `TCC_IDX_CMPA_HI && !(counter_tick) |=> $stable(cmp_a_r) && temp_r == $past(rb.wr_data);
  endproperty
  a_rl5_hold: assert property (p_rl5_hold) else $error("high byte write changed compare a"); // RL5

  property p_rl6_shared;
    wr_go && rb.wr_idx == `TCC_IDX_CMPB_HI |=> temp_r == $past(rb.wr_data);
  endproperty
  a_rl6_shared: assert property (p_rl6_shared) else $error("latch not shared across registers"); // RL6

  property p_rl7_cap;
    cap_evt |=> cap_r == $past(counter_value);
  endproperty
  a_rl7_cap: assert property (p_rl7_cap) else $error("capture did not load counter"); // RL7

  property p_rl8_lo;
    rb.rd_en && rb.rd_idx == `TCC_IDX_CAP_LO |-> rb.rd_data == cap_r[`TCC_LO];
  endproperty
  a_rl8_lo: assert property (p_rl8_lo) else $error("capture low byte mismatch"); // RL8

  property p_rl9_rdlatch;
    rb.rd_en && rb.rd_idx == `TCC_IDX_CAP_LO && !wr_go |=> temp_r == $past(cap_r[`TCC_HI]);
  endproperty
  a_rl9_rdlatch: assert property (p_rl9_rdlatch) else $error("low read did not latch high byte"); // RL9

  property p_rl3_matchb;
    counter_tick && counter_value == cmp_b_r |=> match_b;
  endproperty
  a_rl3_matchb: assert property (p_rl3_matchb) else $error("compare b match missed"); // RL3

  property p_rl3_gate;
    !counter_tick |=> !match_a && !match_b;
  endproperty
  a_rl3_gate: assert property (p_rl3_gate) else $error("match without counter step"); // RL3

  property p_rl4_flaga;
    match_a |=> flag_r[`TCC_EVT_CMPA];
  endproperty
  a_rl4_flaga: assert property (p_rl4_flaga) else $error("compare a match did not set flag"); // RL4

  property p_rl7_flag;
    cap_evt |=> flag_r[`TCC_EVT_CAP];
  endproperty
  a_rl7_flag: assert property (p_rl7_flag) else $error("capture did not set flag"); // RL7

  property p_rl8_wr;
    wr_go && rb.wr_idx == `TCC_IDX_CAP_LO && !cap_evt |=> cap_r == {$past(temp_r), $past(rb.wr_data)};
  endproperty
  a_rl8_wr: assert property (p_rl8_wr) else $error("capture write not built from latch and low byte"); // RL8
endmodule

// ---- verification/tcc_cpu_model.sv ----
/*
  processor side model: axi4-lite master issuing single byte accesses.
  assumes: tasks are called from the bench; answers are awaited without limit.
*/
`timescale 1ns/1ps
module tcc_cpu_model #(
  parameter int AW = 12
) (
  input  wire logic          clk,
  output logic [AW-1:0]      s_axi_awaddr,
  output logic               s_axi_awvalid,
  input  wire logic          s_axi_awready,
  output logic [31:0]        s_axi_wdata,
  output logic [3:0]         s_axi_wstrb,
  output logic               s_axi_wvalid,
  input  wire logic          s_axi_wready,
  input  wire logic [1:0]    s_axi_bresp,
  input  wire logic          s_axi_bvalid,
  output logic               s_axi_bready,
  output logic [AW-1:0]      s_axi_araddr,
  output logic               s_axi_arvalid,
  input  wire logic          s_axi_arready,
  input  wire logic [31:0]   s_axi_rdata,
  input  wire logic [1:0]    s_axi_rresp,
  input  wire logic          s_axi_rvalid,
  output logic               s_axi_rready
);
  // ------------------------------------------------------------------
  // idle levels
  // ------------------------------------------------------------------
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata  = 32'h0;
    s_axi_wstrb  = 4'h1;
  end

  // ------------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat, output logic [1:0] resp);
    bit got;
    @(posedge clk);
    s_axi_awaddr  <= AW'({idx, 2'b00});
    s_axi_wdata   <= {24'h0, dat};
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    got = 0;
    while (!got) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        got = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] dat, output logic [1:0] resp);
    bit got;
    @(posedge clk);
    s_axi_araddr  <= AW'({idx, 2'b00});
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    got = 0;
    while (!got) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        got = 1;
        dat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
endmodule

// ---- verification/tcc_regs_tb.sv ----
/*
  self-checking bench of the compare/capture register block.
  assumes: tcc_cpu_model drives the register bus; counter and pins come from here.
*/
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_regs_tb;
  import tcc_pkg::*;
  logic               clk, resetn;
  logic [11:0]        s_axi_awaddr, s_axi_araddr;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic               s_axi_rvalid, s_axi_rready;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rsp;
  tcc_word_t          counter_value;
  logic               counter_tick, capture_input_pin, comparator_out, match_a, match_b, irq;
  logic [31:0]        rdw;
  int                 bad_count, check_count, cyc;

  tcc_regs #(.AW(12)) tcc_regs_i (.*);
  tcc_cpu_model #(.AW(12)) tcc_cpu_model_i (.*);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat, input logic [1:0] er = 2'h0);
    tcc_cpu_model_i.wr(idx, dat, rsp);
    chk({30'h0, rsp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'h0);
    tcc_cpu_model_i.rd(idx, rdw, rsp);
    chk(rdw, {24'h0, exp}, "read data");
    chk({30'h0, rsp}, {30'h0, er}, "read response");
  endtask

  task automatic step(input tcc_word_t v, input logic t, input logic ea, input logic eb);
    counter_value <= v;
    counter_tick  <= t;
    @(posedge clk);
    counter_tick <= 1'b0;
    #1;
    chk({30'h0, match_a, match_b}, {30'h0, ea, eb}, "match pulse");
    @(posedge clk);
    #1;
    chk({30'h0, match_a, match_b}, 32'h0, "match pulse width");
    @(posedge clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, e}, "interrupt level");
    @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    for (int i = 8'h22; i <= 8'h27; i++) rd(8'(i), 8'h00);
    for (int i = 8'h30; i <= 8'h32; i++) rd(8'(i), 8'h00);
    rd(8'h10, 8'h00, 2'h2);
    wr(8'h10, 8'h5a, 2'h2);
    $display("test reset done");
  endtask

  task automatic t_compare;
    wr(`TCC_IDX_CMPA_HI, 8'h12);
    wr(`TCC_IDX_CMPA_LO, 8'h34);
    rd(`TCC_IDX_CMPA_HI, 8'h12);
    rd(`TCC_IDX_CMPA_LO, 8'h34);
    wr(`TCC_IDX_CMPB_HI, 8'hab);
    wr(`TCC_IDX_CMPB_LO, 8'hcd);
    rd(`TCC_IDX_CMPB_HI, 8'hab);
    rd(`TCC_IDX_CMPB_LO, 8'hcd);
    step(16'h1234, 1'b1, 1'b1, 1'b0);
    step(16'habcd, 1'b1, 1'b0, 1'b1);
    step(16'h1235, 1'b1, 1'b0, 1'b0);
    step(16'h1234, 1'b0, 1'b0, 1'b0);
    rd(`TCC_IDX_STATUS, 8'h03);
    irq_is(1'b0);
    wr(`TCC_IDX_MASK, 8'h01);
    irq_is(1'b1);
    wr(`TCC_IDX_STATUS, 8'h01);
    rd(`TCC_IDX_STATUS, 8'h02);
    irq_is(1'b0);
    wr(`TCC_IDX_STATUS, 8'h02);
    $display("test compare done");
  endtask

  task automatic t_latch;
    wr(`TCC_IDX_CMPA_HI, 8'h56);
    step(16'h1234, 1'b1, 1'b1, 1'b0);
    wr(`TCC_IDX_CMPB_HI, 8'h77);
    wr(`TCC_IDX_CMPA_LO, 8'h34);
    step(16'h7734, 1'b1, 1'b1, 1'b0);
    step(16'habcd, 1'b1, 1'b0, 1'b1);
    wr(`TCC_IDX_STATUS, 8'h07);
    $display("test latch done");
  endtask

  task automatic t_capture;
    counter_value     <= 16'hbeef;
    capture_input_pin <= 1'b1;
    @(posedge clk);
    capture_input_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`TCC_IDX_STATUS, 8'h04);
    rd(`TCC_IDX_CAP_LO, 8'hef);
    rd(`TCC_IDX_CAP_HI, 8'hbe);
    wr(`TCC_IDX_STATUS, 8'h04);
    wr(`TCC_IDX_CTRL, 8'h03);
    counter_value  <= 16'h0a0b;
    comparator_out <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TCC_IDX_STATUS, 8'h04);
    rd(`TCC_IDX_CAP_LO, 8'h0b);
    rd(`TCC_IDX_CAP_HI, 8'h0a);
    wr(`TCC_IDX_CAP_HI, 8'h5a);
    wr(`TCC_IDX_CAP_LO, 8'ha5);
    rd(`TCC_IDX_CAP_LO, 8'ha5);
    rd(`TCC_IDX_CAP_HI, 8'h5a);
    $display("test capture done");
  endtask

  task automatic t_rerun;
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(`TCC_IDX_STATUS, 8'h00);
    rd(`TCC_IDX_CMPA_HI, 8'h00);
    rd(`TCC_IDX_CTRL, 8'h00);
    irq_is(1'b0);
    $display("test rerun done");
  endtask

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      give_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    counter_value = 16'h0000;
    counter_tick = 1'b0;
    capture_input_pin = 1'b0;
    comparator_out = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_compare();
    t_latch();
    t_capture();
    t_rerun();
    give_verdict();
  end
endmodule
